// file: shared/sbr_pkg.sv
package sbr_pkg;
    // Clock
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
    // Bus reset and time slot timing
    localparam int unsigned RST_LOW_US  = 480;
    localparam int unsigned RST_SMP_US  = 550;
    localparam int unsigned RST_END_US  = 960;
    localparam int unsigned SLOT_L0_US  = 60;
    localparam int unsigned SLOT_L1_US  = 6;
    localparam int unsigned SLOT_SMP_US = 15;
    localparam int unsigned SLOT_END_US = 70;
    localparam int unsigned RST_LOW_CYC  = RST_LOW_US * CYC_PER_US;
    localparam int unsigned RST_SMP_CYC  = RST_SMP_US * CYC_PER_US;
    localparam int unsigned RST_END_CYC  = RST_END_US * CYC_PER_US;
    localparam int unsigned SLOT_L0_CYC  = SLOT_L0_US * CYC_PER_US;
    localparam int unsigned SLOT_L1_CYC  = SLOT_L1_US * CYC_PER_US;
    localparam int unsigned SLOT_SMP_CYC = SLOT_SMP_US * CYC_PER_US;
    localparam int unsigned SLOT_END_CYC = SLOT_END_US * CYC_PER_US;
    // Pulse durations
    localparam int unsigned SPU_MS  = 524;
    localparam int unsigned SPU_CYC = SPU_MS * 1000 * CYC_PER_US;
    localparam int unsigned VPP_US  = 512;
    localparam int unsigned VPP_CYC = VPP_US * CYC_PER_US;
    // Serial rate
    localparam int unsigned BAUD_BASE    = 9600;
    localparam int unsigned BAUD_DIV_CYC = CLK_HZ / BAUD_BASE;
    // Command and reply codes
    localparam logic [7:0] CMD_DATA  = 8'hE1;
    localparam logic [7:0] CMD_CMDM  = 8'hE3;
    localparam logic [7:0] CMD_TERM  = 8'hF1;
    localparam logic [7:0] CMD_PROG  = 8'hFD;
    localparam logic [7:0] PRES_OK   = 8'hC9;
    localparam logic [7:0] PRES_NONE = 8'hCB;
    localparam logic [7:0] PRESP_SPU = 8'hEC;
    // Configuration parameter selectors and values
    localparam logic [2:0] CFG_VPP  = 3'h2;
    localparam logic [2:0] CFG_SPU  = 3'h3;
    localparam logic [2:0] CFG_RATE = 3'h7;
    localparam logic [2:0] DUR_INF  = 3'h7;
    // Values after reset
    localparam logic [2:0] RATE_RST = 3'h0;
    localparam logic [2:0] DUR_RST  = 3'h4;

    typedef struct packed {
        logic       bus_rst;
        logic [7:0] data;
    } sbr_req_t;

    typedef struct packed {
        logic       present;
        logic [7:0] data;
    } sbr_rsp_t;

    typedef enum {ST_IDLE, ST_BUS, ST_PULSE, ST_PRESP} sbr_state_t;
    typedef enum {SL_IDLE, SL_RESET, SL_SLOT} sbr_slot_t;
endpackage : sbr_pkg

// file: rtl/sbr_slot.sv
`timescale 1ns/10ps
module sbr_slot
    import sbr_pkg::*;
#(
    parameter int unsigned RST_LOW  = RST_LOW_CYC,
    parameter int unsigned RST_SMP  = RST_SMP_CYC,
    parameter int unsigned RST_END  = RST_END_CYC,
    parameter int unsigned SLOT_L0  = SLOT_L0_CYC,
    parameter int unsigned SLOT_END = SLOT_END_CYC
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Request and answer
    input  wire logic     start,
    input  wire sbr_req_t req,
    output sbr_rsp_t      rsp,
    output logic          done,
    // Bus line
    input  wire logic     bus_in,
    output logic          bus_low
);
    sbr_slot_t   st;
    sbr_slot_t   next_st;
    logic [16:0] cnt;
    logic [16:0] next_cnt;
    logic [2:0]  bitn;
    logic [2:0]  next_bitn;
    logic [7:0]  wr;
    logic [7:0]  next_wr;
    logic        smp;
    logic        next_smp;
    sbr_rsp_t    next_rsp;
    logic        next_done;

    always_comb begin
        next_st   = st;
        next_cnt  = cnt + 17'h1;
        next_bitn = bitn;
        next_wr   = wr;
        next_smp  = smp;
        next_rsp  = rsp;
        next_done = 1'b0;
        bus_low   = 1'b0;
        case (st)
            SL_IDLE: begin
                next_cnt = '0;
                if (start) begin
                    next_st   = req.bus_rst ? SL_RESET : SL_SLOT;
                    next_wr   = req.data;
                    next_bitn = '0;
                end
            end
            SL_RESET: begin
                bus_low = cnt < 17'(RST_LOW);
                if (cnt == 17'(RST_SMP)) begin
                    next_rsp.present = ~bus_in;
                end
                if (cnt == 17'(RST_END - 1)) begin
                    next_st   = SL_IDLE;
                    next_done = 1'b1;
                end
            end
            SL_SLOT: begin
                bus_low = cnt < (wr[0] ? 17'(SLOT_L1_CYC) : 17'(SLOT_L0));
                if (cnt == 17'(SLOT_SMP_CYC)) begin
                    next_smp = bus_in;
                end
                if (cnt == 17'(SLOT_END - 1)) begin
                    next_cnt      = '0;
                    next_wr       = {1'b0, wr[7:1]};
                    next_rsp.data = {smp, rsp.data[7:1]};
                    next_bitn     = bitn + 3'h1;
                    if (bitn == 3'h7) begin
                        next_st   = SL_IDLE;
                        next_done = 1'b1;
                    end
                end
            end
            default: next_st = SL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st   <= SL_IDLE;
            cnt  <= '0;
            bitn <= '0;
            wr   <= '0;
            smp  <= 1'b0;
            rsp  <= '0;
            done <= 1'b0;
        end else begin
            st   <= next_st;
            cnt  <= next_cnt;
            bitn <= next_bitn;
            wr   <= next_wr;
            smp  <= next_smp;
            rsp  <= next_rsp;
            done <= next_done;
        end
    end
endmodule : sbr_slot

// file: rtl/sbr_bridge.sv
`timescale 1ns/10ps
module sbr_bridge
    import sbr_pkg::*;
#(
    parameter int unsigned RST_LOW  = RST_LOW_CYC,
    parameter int unsigned RST_SMP  = RST_LOW * RST_SMP_US / RST_LOW_US,
    parameter int unsigned RST_END  = RST_LOW * RST_END_US / RST_LOW_US,
    parameter int unsigned SLOT_L0  = SLOT_L0_CYC,
    parameter int unsigned SLOT_END = SLOT_L0 * SLOT_END_US / SLOT_L0_US,
    parameter int unsigned BAUD_DIV = BAUD_DIV_CYC,
    parameter int unsigned SPU_LEN  = SPU_CYC,
    parameter int unsigned VPP_LEN  = VPP_CYC
) (
    // Clock and reset
    input  wire logic CLOCK,
    input  wire logic RST,
    // Host serial
    input  wire logic RXD,
    output logic      TXD,
    // Bus pin and drivers
    input  wire logic BUS_IN,
    output logic      BUS_OUT,
    output logic      BUS_OE,
    output logic      SPU_EN,
    output logic      VPP_EN,
    // Status
    output logic      DATA_MODE
);
    logic        rxd_s1, rxd_s2, bus_s1, bus_s2;
    logic [2:0]  rate;
    logic [15:0] div;
    logic        rx_line;
    // Receive group
    logic        rx_busy, next_rx_busy, rx_full, next_rx_full;
    logic [15:0] rx_cnt, next_rx_cnt;
    logic [3:0]  rx_bit, next_rx_bit;
    logic [7:0]  rx_sh, next_rx_sh, hold, next_hold;
    // Transmit group
    logic        tx_busy, next_tx_busy, tx_line, next_tx_line;
    logic [15:0] tx_cnt, next_tx_cnt;
    logic [3:0]  tx_bit, next_tx_bit;
    logic [8:0]  tx_sh, next_tx_sh;
    // Control group
    sbr_state_t  state, next_state;
    logic        data_mode, next_data_mode, armed, next_armed;
    logic [2:0]  next_rate, spu_val, next_spu_val, vpp_val, next_vpp_val;
    logic [25:0] pcnt, next_pcnt;
    logic        spu_en, next_spu_en, vpp_en, next_vpp_en;
    logic        tx_req, next_tx_req, was_rst, next_was_rst;
    logic [7:0]  tx_byte, next_tx_byte, resp, next_resp;
    logic        slot_start, take, term, consume, pulse_end;
    sbr_req_t    slot_req;
    sbr_rsp_t    slot_rsp;
    logic        slot_done, slot_low;

    sbr_slot #(
        .RST_LOW  (RST_LOW),
        .RST_SMP  (RST_SMP),
        .RST_END  (RST_END),
        .SLOT_L0  (SLOT_L0),
        .SLOT_END (SLOT_END)
    ) u_slot (
        .clk     (CLOCK),
        .rst     (RST),
        .start   (slot_start),
        .req     (slot_req),
        .rsp     (slot_rsp),
        .done    (slot_done),
        .bus_in  (bus_s2),
        .bus_low (slot_low)
    );

    always_comb begin
        case (rate[1:0])
            2'h0:    div = 16'(BAUD_DIV);
            2'h1:    div = 16'(BAUD_DIV / 2);
            2'h2:    div = 16'(BAUD_DIV / 6);
            default: div = 16'(BAUD_DIV / 12);
        endcase
    end

    assign rx_line = rxd_s2 ^ rate[2];
    assign take    = (state == ST_IDLE) && rx_full && !tx_busy && !tx_req;
    assign term    = (state == ST_PULSE) && rx_full && !data_mode && (hold == CMD_TERM);
    assign consume = take || term;

    // Receiver with one-byte holding register
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_cnt  = rx_cnt;
        next_rx_bit  = rx_bit;
        next_rx_sh   = rx_sh;
        next_hold    = hold;
        next_rx_full = rx_full && !consume;
        if (!rx_busy) begin
            if (!rx_line) begin
                next_rx_busy = 1'b1;
                next_rx_cnt  = div >> 1;
                next_rx_bit  = '0;
            end
        end else if (rx_cnt == '0) begin
            next_rx_cnt = div - 16'h1;
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0) begin
                next_rx_busy = !rx_line;
            end else if (rx_bit < 4'h9) begin
                next_rx_sh = {rx_line, rx_sh[7:1]};
            end else begin
                next_rx_busy = 1'b0;
                if (rx_line && next_rx_full == 1'b0) begin
                    next_hold    = rx_sh;
                    next_rx_full = 1'b1;
                end
            end
        end else begin
            next_rx_cnt = rx_cnt - 16'h1;
        end
    end

    // Transmitter
    always_comb begin
        next_tx_busy = tx_busy;
        next_tx_cnt  = tx_cnt;
        next_tx_bit  = tx_bit;
        next_tx_sh   = tx_sh;
        next_tx_line = tx_line;
        if (!tx_busy) begin
            if (tx_req) begin
                next_tx_busy = 1'b1;
                next_tx_line = 1'b0;
                next_tx_sh   = {1'b1, tx_byte};
                next_tx_bit  = '0;
                next_tx_cnt  = div - 16'h1;
            end
        end else if (tx_cnt == '0) begin
            next_tx_cnt = div - 16'h1;
            if (tx_bit == 4'h9) begin
                next_tx_busy = 1'b0;
            end else begin
                next_tx_line = tx_sh[0];
                next_tx_sh   = {1'b1, tx_sh[8:1]};
                next_tx_bit  = tx_bit + 4'h1;
            end
        end else begin
            next_tx_cnt = tx_cnt - 16'h1;
        end
    end

    assign pulse_end = vpp_en ? (vpp_val != DUR_INF && pcnt == 26'(VPP_LEN - 1))
                              : (spu_val != DUR_INF && pcnt == 26'(SPU_LEN - 1));

    // Command interpreter
    always_comb begin
        next_state     = state;
        next_data_mode = data_mode;
        next_armed     = armed;
        next_rate      = rate;
        next_spu_val   = spu_val;
        next_vpp_val   = vpp_val;
        next_pcnt      = '0;
        next_spu_en    = spu_en;
        next_vpp_en    = vpp_en;
        next_tx_req    = 1'b0;
        next_tx_byte   = tx_byte;
        next_resp      = resp;
        next_was_rst   = was_rst;
        slot_start     = 1'b0;
        slot_req       = '{bus_rst: 1'b0, data: hold};
        case (state)
            ST_IDLE: begin
                if (take && data_mode) begin
                    if (hold == CMD_CMDM) begin
                        next_data_mode = 1'b0;
                    end else begin
                        slot_start   = 1'b1;
                        next_was_rst = 1'b0;
                        next_state   = ST_BUS;
                    end
                end else if (take) begin
                    if (hold == CMD_DATA) begin
                        next_data_mode = 1'b1;
                    end else if (hold[7:4] == 4'hC && hold[0]) begin
                        slot_start       = 1'b1;
                        slot_req.bus_rst = 1'b1;
                        next_was_rst     = 1'b1;
                        next_state       = ST_BUS;
                    end else if (hold[7:2] == 6'b1110_11 && hold[0]) begin
                        next_armed  = hold[1];
                        next_spu_en = 1'b1;
                        next_resp   = {hold[7:2], 2'b00};
                        next_state  = ST_PULSE;
                    end else if (hold == CMD_PROG) begin
                        next_vpp_en = 1'b1;
                        next_resp   = {hold[7:2], 2'b00};
                        next_state  = ST_PULSE;
                    end else if (!hold[7] && hold[0]) begin
                        case (hold[6:4])
                            CFG_VPP:  next_vpp_val = hold[3:1];
                            CFG_SPU:  next_spu_val = hold[3:1];
                            CFG_RATE: next_rate    = hold[3:1];
                            default:  next_rate    = rate;
                        endcase
                        next_tx_req  = 1'b1;
                        next_tx_byte = {hold[7:1], 1'b0};
                    end
                end
            end
            ST_BUS: begin
                if (slot_done) begin
                    next_tx_req  = 1'b1;
                    next_tx_byte = was_rst ? (slot_rsp.present ? PRES_OK : PRES_NONE)
                                           : slot_rsp.data;
                    next_state   = ST_IDLE;
                    if (!was_rst && armed) begin
                        next_spu_en = 1'b1;
                        next_resp   = PRESP_SPU;
                        next_state  = ST_PULSE;
                    end
                end
            end
            ST_PULSE: begin
                next_pcnt = pcnt + 26'h1;
                if (term || pulse_end) begin
                    next_spu_en = 1'b0;
                    next_vpp_en = 1'b0;
                    next_state  = ST_PRESP;
                end
            end
            ST_PRESP: begin
                if (!tx_busy && !tx_req) begin
                    next_tx_req  = 1'b1;
                    next_tx_byte = resp;
                    next_state   = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            {rxd_s1, rxd_s2, bus_s1, bus_s2} <= 4'hF;
            rx_busy <= 1'b0;
            rx_cnt  <= '0;
            rx_bit  <= '0;
            rx_sh   <= '0;
            hold    <= '0;
            rx_full <= 1'b0;
            tx_busy <= 1'b0;
            tx_cnt  <= '0;
            tx_bit  <= '0;
            tx_sh   <= '1;
            tx_line <= 1'b1;
            TXD     <= 1'b1;
        end else begin
            rxd_s1  <= RXD;
            rxd_s2  <= rxd_s1;
            bus_s1  <= BUS_IN;
            bus_s2  <= bus_s1;
            rx_busy <= next_rx_busy;
            rx_cnt  <= next_rx_cnt;
            rx_bit  <= next_rx_bit;
            rx_sh   <= next_rx_sh;
            hold    <= next_hold;
            rx_full <= next_rx_full;
            tx_busy <= next_tx_busy;
            tx_cnt  <= next_tx_cnt;
            tx_bit  <= next_tx_bit;
            tx_sh   <= next_tx_sh;
            tx_line <= next_tx_line;
            TXD     <= next_tx_line ^ next_rate[2];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state     <= ST_IDLE;
            data_mode <= 1'b0;
            armed     <= 1'b0;
            rate      <= RATE_RST;
            spu_val   <= DUR_RST;
            vpp_val   <= DUR_RST;
            pcnt      <= '0;
            spu_en    <= 1'b0;
            vpp_en    <= 1'b0;
            tx_req    <= 1'b0;
            tx_byte   <= '0;
            resp      <= '0;
            was_rst   <= 1'b0;
            BUS_OE    <= 1'b0;
            BUS_OUT   <= 1'b0;
        end else begin
            state     <= next_state;
            data_mode <= next_data_mode;
            armed     <= next_armed;
            rate      <= next_rate;
            spu_val   <= next_spu_val;
            vpp_val   <= next_vpp_val;
            pcnt      <= next_pcnt;
            spu_en    <= next_spu_en;
            vpp_en    <= next_vpp_en;
            tx_req    <= next_tx_req;
            tx_byte   <= next_tx_byte;
            resp      <= next_resp;
            was_rst   <= next_was_rst;
            BUS_OE    <= slot_low;
            BUS_OUT   <= 1'b0;
        end
    end

    assign SPU_EN    = spu_en;
    assign VPP_EN    = vpp_en;
    assign DATA_MODE = data_mode;

    chk_reset_reply: assert property (@(posedge CLOCK) disable iff (RST)
        (state == ST_BUS && slot_done && was_rst) |=> tx_req && tx_byte[7:2] == PRES_OK[7:2])
        else $error("reset answer missing");
    chk_mode_silent: assert property (@(posedge CLOCK) disable iff (RST)
        (take && !data_mode && hold == CMD_DATA) |=> data_mode && !tx_req [*2])
        else $error("data mode switch not silent");
    chk_echo_byte: assert property (@(posedge CLOCK) disable iff (RST)
        (state == ST_BUS && slot_done && !was_rst) |=> tx_req && tx_byte == $past(slot_rsp.data))
        else $error("read byte not returned");
    chk_cfg_reply: assert property (@(posedge CLOCK) disable iff (RST)
        (take && !data_mode && !hold[7] && hold[0]) |=> tx_req && tx_byte == ($past(hold) & 8'hFE))
        else $error("config answer wrong");
    chk_pulse_quiet: assert property (@(posedge CLOCK) disable iff (RST)
        (take && !data_mode && hold[7:2] == 6'b1110_11 && hold[0])
        |=> (state == ST_PULSE && SPU_EN && !tx_req) ##1 !tx_req)
        else $error("pulse command answered early");
    chk_armed_spu: assert property (@(posedge CLOCK) disable iff (RST)
        (state == ST_BUS && slot_done && !was_rst && armed)
        |=> SPU_EN && tx_req && resp == PRESP_SPU)
        else $error("armed pull-up not started");
    chk_prog_pulse: assert property (@(posedge CLOCK) disable iff (RST)
        (take && !data_mode && hold == CMD_PROG) |=> VPP_EN && state == ST_PULSE && !tx_req)
        else $error("program pulse not applied");
    chk_txd_polarity: assert property (@(posedge CLOCK) disable iff (RST)
        (!tx_busy && $past(!tx_busy) && $stable(rate)) |-> TXD == ~rate[2])
        else $error("idle serial level wrong");
    chk_hold_byte: assert property (@(posedge CLOCK) disable iff (RST)
        (rx_full && !consume) |=> rx_full && hold == $past(hold))
        else $error("held byte lost");
    chk_term_only: assert property (@(posedge CLOCK) disable iff (RST)
        term |=> !SPU_EN && !VPP_EN && !tx_req ##1 (tx_req || tx_busy))
        else $error("terminate handling wrong");
    chk_start_cmd: assert property (@(posedge CLOCK) disable iff (RST)
        $past(RST) |-> !data_mode && !armed && !SPU_EN)
        else $error("not in command mode after reset");
endmodule : sbr_bridge

// file: tb/sbr_host.sv
`timescale 1ns/10ps
module sbr_host #(
    parameter int unsigned DIV = 48
) (
    // Clock
    input  wire logic clk,
    // Serial lines
    input  wire logic txd,
    output logic      rxd
);
    logic inv = 1'b0;
    initial rxd = 1'b1;
    // Line polarity; idle level follows it when asked
    task automatic set_inv(input logic v, input logic idle_now);
        inv = v;
        if (idle_now) rxd <= 1'b1 ^ v;
    endtask : set_inv
    // Frame out, LSB first
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i] ^ inv;
            repeat (DIV - 1) @(posedge clk);
        end
    endtask : send
    // Frame in, unknown when absent or bad stop
    task automatic recv(input int tmo, output logic [7:0] b);
        logic [7:0] t;
        int n;
        b = 'x;
        for (n = 0; n < tmo && (txd ^ inv) !== 1'b0; n++) @(posedge clk);
        if (n < tmo) begin
            repeat (DIV + DIV / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                t[i] = txd ^ inv;
                repeat (DIV) @(posedge clk);
            end
            if ((txd ^ inv) === 1'b1) b = t;
        end
    endtask : recv
endmodule : sbr_host

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import sbr_pkg::*;
    localparam int unsigned VPP = 100;
    localparam int unsigned SPU = 200;
    logic clk, rst = 1'b1, rxd, txd, bus_in, bus_out, bus_oe;
    logic spu_en, vpp_en, data_mode, present = 1'b1;
    int   lowc = 0, pc = 0, vcnt = 0, spuc = 0, fail_count = 0, num_checks = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sbr_bridge #(.RST_LOW(40), .SLOT_L0(1600), .BAUD_DIV(48), .SPU_LEN(SPU),
        .VPP_LEN(VPP)) i_sbr_bridge (
        .CLOCK(clk), .RST(rst), .RXD(rxd), .TXD(txd), .BUS_IN(bus_in),
        .BUS_OUT(bus_out), .BUS_OE(bus_oe), .SPU_EN(spu_en), .VPP_EN(vpp_en),
        .DATA_MODE(data_mode));
    sbr_host i_sbr_host (.clk(clk), .txd(txd), .rxd(rxd));
    // Pulled-up wire with one slave answering a reset low
    assign bus_in = !(bus_oe && !bus_out) && pc == 0;
    always @(posedge clk) begin
        lowc <= bus_oe ? lowc + 1 : 0;
        if (!bus_oe && lowc >= 30 && lowc < 100 && present) pc <= 12;
        else if (pc > 0) pc <= pc - 1;
        if (vpp_en) vcnt <= vcnt + 1;
        if (spu_en) spuc <= spuc + 1;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic rx(input logic [7:0] e, input int tmo = 20000);
        logic [7:0] b;
        i_sbr_host.recv(tmo, b);
        check($sformatf("reply, expecting %h", e), b, e);
    endtask : rx
    task automatic xfer(input logic [7:0] b, input logic [7:0] e, input int tmo = 20000);
        i_sbr_host.send(b);
        rx(e, tmo);
    endtask : xfer
    task automatic t_reset();
        check("data mode", {7'h0, data_mode}, 8'h00);
        check("pull-up", {7'h0, spu_en}, 8'h00);
        check("serial idle", {7'h0, txd}, 8'h01);
        check("drivers", {5'h0, vpp_en, bus_oe, bus_out}, 8'h00);
    endtask : t_reset
    task automatic t_bus_reset();
        xfer(8'hC1, PRES_OK);
        present = 1'b0;
        xfer(8'hC1, PRES_NONE);
        present = 1'b1;
    endtask : t_bus_reset
    task automatic t_config();
        xfer(8'h39, 8'h38);
        xfer(8'h29, 8'h28);
    endtask : t_config
    task automatic t_data();
        xfer(8'hE1, 8'hxx, 600);
        check("data mode", {7'h0, data_mode}, 8'h01);
        i_sbr_host.send(8'h0F);
        i_sbr_host.send(8'h40);
        rx(8'h0F);
        rx(8'h40);
        xfer(8'hE3, 8'hxx, 600);
        check("data mode", {7'h0, data_mode}, 8'h00);
    endtask : t_data
    task automatic t_pulse();
        int s0;
        xfer(8'h3F, 8'h3E);
        xfer(8'hEF, 8'hxx, 600);
        check("pull-up", {7'h0, spu_en}, 8'h01);
        xfer(8'hF1, PRESP_SPU);
        check("pull-up", {7'h0, spu_en}, 8'h00);
        xfer(8'h39, 8'h38);
        xfer(8'hE1, 8'hxx, 600);
        s0 = spuc;
        xfer(8'h44, 8'h44);
        rx(PRESP_SPU);
        check("pull-up length", {7'h0, spuc - s0 >= SPU && spuc - s0 <= SPU + 2}, 8'h01);
        xfer(8'hE3, 8'hxx, 600);
        xfer(8'hED, PRESP_SPU);
        xfer(8'hE1, 8'hxx, 600);
        xfer(8'h44, 8'h44);
        rx(8'hxx, 800);
        xfer(8'hE3, 8'hxx, 600);
    endtask : t_pulse
    task automatic t_prog();
        int v0;
        v0 = vcnt;
        xfer(CMD_PROG, 8'hFC);
        check("prog length", {7'h0, vcnt - v0 >= VPP && vcnt - v0 <= VPP + 2}, 8'h01);
    endtask : t_prog
    task automatic t_polarity();
        int n;
        fork
            i_sbr_host.send(8'h79);
            begin
                repeat (48 * 9 + 8) @(posedge clk);
                i_sbr_host.set_inv(1'b1, 1'b0);
                for (n = 0; n < 200 && txd !== 1'b0; n++) @(posedge clk);
                i_sbr_host.set_inv(1'b1, 1'b1);
                rx(8'h78);
            end
        join
        xfer(8'h29, 8'h28);
    endtask : t_polarity
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_bus_reset();
        t_config();
        t_data();
        t_pulse();
        t_prog();
        t_polarity();
        print_verdict();
    end
endmodule : testbench
